// *** srcc_pkg.sv ***
package srcc_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned SK_HZ = 1000000;
  localparam int unsigned SK_HALF_CYC = CLK_HZ / (2 * SK_HZ);
  localparam logic [15:0] CMD_RESET = 16'h4000;
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned ADDR_MSB = 5;
  localparam int unsigned SUB_LSB = 6;
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned STYLE_BIT = 12;
  localparam int unsigned TYPE_BIT = 13;
  localparam int unsigned ONE_BIT = 14;
  localparam int unsigned BUSY_BIT = 15;
  localparam logic [1:0] OPC_SUB = 2'h0;
  localparam logic [1:0] OPC_STORE = 2'h1;
  localparam logic [1:0] OPC_FETCH = 2'h2;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h2;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;
  localparam logic [1:0] ROM_READ = 2'h2;
  localparam logic [1:0] ROM_WRITE = 2'h1;
  localparam logic [1:0] ROM_ERASE = 2'h3;
  localparam logic [1:0] ROM_EXT = 2'h0;
  localparam logic [5:0] EXT_LOCK = 6'h00;
  localparam logic [5:0] EXT_FILL = 6'h10;
  localparam logic [5:0] EXT_CLEAR = 6'h20;
  localparam logic [5:0] EXT_UNLOCK = 6'h30;
  localparam logic [5:0] SPECIAL_ADDR_XOR = 6'h3F;
  localparam logic [5:0] FRAME_BITS = 6'h09;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [15:0] BUSY_LIMIT = 16'hFFFF;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEND = 3'b001,
    ST_DATA = 3'b010,
    ST_WAIT = 3'b011,
    ST_GAP = 3'b100
  } srcc_state_type;
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } srcc_pins_type;
  typedef struct packed {
    logic [1:0] op;
    logic [5:0] addr;
    logic with_data;
    logic read;
    logic relock;
  } srcc_frame_type;
endpackage

// *** srcc_clkdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
module srcc_clkdiv import srcc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  logic [7:0] cnt_q;
  logic wrap;
  assign wrap = (cnt_q == 8'(SK_HALF_CYC - 1));
  assign tick = run & wrap;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (!run || wrap) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** srcc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
//Contract
//- Word index bits 5:0 select target word
//- Sub-command decoded only when opcode zero
//- Sub-command ignored for nonzero opcode
//- Opcode 01 store, 10 fetch
//- Auto lock after every modifying command
//- Style bit picks normal or special address
//- Bit 13 reports attached ROM type
//- Busy bit high whole execution
//- Data register holds fetched or store word
module srcc_top import srcc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  input wire logic buf_wr,
  input wire logic [15:0] buf_wdata,
  output logic [15:0] buf_rdata,
  input wire logic attached_rom_type,
  output logic rom_cs,
  output logic rom_sk,
  output logic rom_di,
  input wire logic rom_do
);
  logic rs1_q, rs2_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire rst_i = rs2_q;

  srcc_state_type st_q, st_d;
  logic [5:0] idx_q;
  logic [1:0] sub_q, opc_q;
  logic style_q;
  logic [15:0] buf_q;
  logic [15:0] sh_q;
  logic [5:0] cnt_q;
  logic phase_q;
  logic [15:0] wait_q;
  srcc_frame_type fr_q;
  srcc_pins_type pins_q;
  logic busy;
  logic tick;

  function automatic srcc_frame_type decode(input logic [1:0] opc, input logic [1:0] sub,
                                            input logic [5:0] a, input logic style);
    srcc_frame_type f;
    logic [5:0] wa;
    f = '0;
    wa = style ? a : (a ^ SPECIAL_ADDR_XOR);
    unique case (opc)
      OPC_STORE: begin
        f.op = ROM_WRITE;
        f.addr = wa;
        f.with_data = 1'b1;
        f.relock = 1'b1;
      end
      OPC_FETCH: begin
        f.op = ROM_READ;
        f.addr = wa;
        f.read = 1'b1;
      end
      OPC_SUB: begin
        f.op = ROM_EXT;
        unique case (sub)
          SUB_FILL: begin
            f.addr = EXT_FILL;
            f.with_data = 1'b1;
            f.relock = 1'b1;
          end
          SUB_CLEAR: begin
            f.addr = EXT_CLEAR;
            f.relock = 1'b1;
          end
          SUB_UNLOCK: f.addr = EXT_UNLOCK;
          default: f.addr = EXT_LOCK;
        endcase
      end
      default: begin
        f.op = ROM_ERASE;
        f.addr = wa;
        f.relock = 1'b1;
      end
    endcase
    return f;
  endfunction

  wire start = cmd_wr & ~busy;
  wire srcc_frame_type new_fr = decode(cmd_wdata[OPC_LSB+1:OPC_LSB],
      cmd_wdata[SUB_LSB+1:SUB_LSB], cmd_wdata[ADDR_MSB:ADDR_LSB], cmd_wdata[STYLE_BIT]);
  wire srcc_frame_type lock_fr = '{op: ROM_EXT, addr: EXT_LOCK, with_data: 1'b0,
      read: 1'b0, relock: 1'b0};
  wire bit_done = tick & phase_q;
  wire last_bit = (cnt_q == 6'h01);

  srcc_clkdiv u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_i),
    .run(st_q == ST_SEND || st_q == ST_DATA),
    .tick(tick)
  );

  assign busy = (st_q != ST_IDLE);
  assign cmd_rdata = {busy, 1'b1, attached_rom_type, style_q, 2'h0, opc_q, sub_q, idx_q};
  assign buf_rdata = buf_q;
  assign rom_cs = pins_q.cs;
  assign rom_sk = pins_q.sk;
  assign rom_di = pins_q.di;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (start) st_d = ST_SEND;
      ST_SEND: if (bit_done && last_bit) begin
        // Self-timed erase holds busy until ready as well
        if (fr_q.with_data || fr_q.read) st_d = ST_DATA;
        else st_d = fr_q.relock ? ST_WAIT : ST_GAP;
      end
      ST_DATA: if (bit_done && last_bit) st_d = fr_q.with_data ? ST_WAIT : ST_GAP;
      ST_WAIT: if (rom_do || wait_q == BUSY_LIMIT) st_d = ST_GAP;
      ST_GAP: st_d = fr_q.relock ? ST_SEND : ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_i) begin
    if (!rst_i) begin
      st_q <= ST_IDLE;
      idx_q <= CMD_RESET[ADDR_MSB:ADDR_LSB];
      sub_q <= CMD_RESET[SUB_LSB+1:SUB_LSB];
      opc_q <= CMD_RESET[OPC_LSB+1:OPC_LSB];
      style_q <= CMD_RESET[STYLE_BIT];
      buf_q <= 16'h0000;
      sh_q <= 16'h0000;
      cnt_q <= 6'h00;
      phase_q <= 1'b0;
      wait_q <= 16'h0000;
      fr_q <= '0;
      pins_q <= '0;
    end else begin
      st_q <= st_d;
      if (buf_wr && !busy) buf_q <= buf_wdata;
      if (tick) phase_q <= ~phase_q;
      unique case (st_q)
        ST_IDLE: begin
          pins_q <= '0;
          if (start) begin
            idx_q <= cmd_wdata[ADDR_MSB:ADDR_LSB];
            sub_q <= cmd_wdata[SUB_LSB+1:SUB_LSB];
            opc_q <= cmd_wdata[OPC_LSB+1:OPC_LSB];
            style_q <= cmd_wdata[STYLE_BIT];
            fr_q <= new_fr;
            cnt_q <= FRAME_BITS;
            phase_q <= 1'b0;
            pins_q <= '{cs: 1'b1, sk: 1'b0, di: 1'b1};
            sh_q <= {new_fr.op, new_fr.addr, 8'h00};
          end
        end
        ST_SEND, ST_DATA: begin
          // Select dropped in the gap, raised again with the start bit
          if (st_q == ST_SEND && !pins_q.cs) begin
            pins_q.cs <= 1'b1;
            pins_q.di <= 1'b1;
          end
          if (tick && !phase_q) begin
            pins_q.sk <= 1'b1;
            if (fr_q.read && st_q == ST_DATA) sh_q <= {sh_q[14:0], rom_do};
          end
          if (bit_done) begin
            pins_q.sk <= 1'b0;
            cnt_q <= cnt_q - 6'h01;
            if (!(fr_q.read && st_q == ST_DATA)) begin
              pins_q.di <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
            end
            if (last_bit) begin
              cnt_q <= DATA_BITS;
              if (fr_q.with_data) begin
                sh_q <= {buf_q[14:0], 1'b0};
                pins_q.di <= buf_q[15];
              end
              if (st_q == ST_DATA || !(fr_q.with_data || fr_q.read)) begin
                pins_q.cs <= fr_q.relock;
                pins_q.di <= 1'b0;
                wait_q <= 16'h0000;
              end
            end
          end
        end
        ST_WAIT: begin
          wait_q <= wait_q + 16'h0001;
          pins_q.di <= 1'b0;
        end
        ST_GAP: begin
          pins_q <= '0;
          if (fr_q.read) buf_q <= sh_q;
          if (fr_q.relock) begin
            fr_q <= lock_fr;
            cnt_q <= FRAME_BITS;
            phase_q <= 1'b0;
            sh_q <= {lock_fr.op, lock_fr.addr, 8'h00};
          end
        end
        default: pins_q <= '0;
      endcase
    end
  end

  property p_busy_on_start;
    @(posedge clk_sys) disable iff (!rst_i) start |=> busy;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("busy not set");
  property p_relock;
    @(posedge clk_sys) disable iff (!rst_i)
      (st_q == ST_GAP && fr_q.relock) |=> (fr_q.addr == EXT_LOCK && st_q == ST_SEND);
  endproperty
  a_relock: assert property (p_relock) else $error("no automatic lock");
  property p_sub_ignored;
    @(posedge clk_sys) disable iff (!rst_i)
      (start && cmd_wdata[OPC_LSB+1:OPC_LSB] == OPC_FETCH) |=> fr_q.op == ROM_READ;
  endproperty
  a_sub_ignored: assert property (p_sub_ignored) else $error("fetch misdecoded");
  property p_idx;
    @(posedge clk_sys) disable iff (!rst_i)
      start |=> idx_q == $past(cmd_wdata[ADDR_MSB:ADDR_LSB]);
  endproperty
  a_idx: assert property (p_idx) else $error("word index lost");
  property p_style;
    @(posedge clk_sys) disable iff (!rst_i)
      (start && cmd_wdata[STYLE_BIT] && cmd_wdata[OPC_LSB+1:OPC_LSB] == OPC_STORE)
      |=> fr_q.addr == $past(cmd_wdata[ADDR_MSB:ADDR_LSB]);
  endproperty
  a_style: assert property (p_style) else $error("normal address altered");
  property p_unlock;
    @(posedge clk_sys) disable iff (!rst_i)
      (start && cmd_wdata[9:6] == 4'h3) |=> (fr_q.addr == EXT_UNLOCK && !fr_q.relock);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock misdecoded");
  property p_type;
    @(posedge clk_sys) disable iff (!rst_i) cmd_rdata[TYPE_BIT] == attached_rom_type;
  endproperty
  a_type: assert property (p_type) else $error("type bit wrong");
  property p_cs;
    @(posedge clk_sys) disable iff (!rst_i) rom_cs |-> busy;
  endproperty
  a_cs: assert property (p_cs) else $error("select without busy");
  property p_gap_cs;
    @(posedge clk_sys) disable iff (!rst_i) st_q == ST_GAP |=> !rom_cs;
  endproperty
  a_gap_cs: assert property (p_gap_cs) else $error("select held between frames");
  property p_bit14;
    @(posedge clk_sys) disable iff (!rst_i) cmd_rdata[ONE_BIT] && cmd_rdata[BUSY_BIT] == busy;
  endproperty
  a_bit14: assert property (p_bit14) else $error("status bits wrong");
  c_fetch: cover property (@(posedge clk_sys) disable iff (!rst_i)
      st_q == ST_GAP && fr_q.read);
  c_store: cover property (@(posedge clk_sys) disable iff (!rst_i)
      st_q == ST_WAIT ##1 st_q == ST_GAP);
  c_unlock: cover property (@(posedge clk_sys) disable iff (!rst_i)
      start && cmd_wdata[9:6] == 4'h3);
endmodule
`default_nettype wire

// *** srcc_rom_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module srcc_rom_model import srcc_pkg::*; #(
  parameter int RDY_NS = 2000
) (
  input wire logic rom_cs,
  input wire logic rom_sk,
  input wire logic rom_di,
  output logic rom_do
);
  logic [15:0] mem [64];
  logic [15:0] rd_q;
  logic [24:0] sh_q;
  logic [1:0] op_q;
  logic [5:0] ad_q;
  logic unlocked_q;
  int n_q;
  event done_ev;
  initial begin
    rom_do = 1'b0;
    unlocked_q = 1'b0;
    n_q = 0;
    sh_q = '0;
    for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
  end
  // Released line shows the inverse of its last value
  always @(negedge rom_cs) begin
    n_q = 0;
    rom_do = ~rom_do;
  end
  always @(done_ev) begin
    rom_do = 1'b0;
    #(RDY_NS) rom_do = 1'b1;
  end
  always @(posedge rom_sk) begin
    if (rom_cs && (n_q > 0 || rom_di)) begin
      sh_q = {sh_q[23:0], rom_di};
      n_q++;
      if (n_q == 9) begin
        op_q = sh_q[7:6];
        ad_q = sh_q[5:0];
        if (op_q == ROM_READ) rd_q = mem[ad_q];
        if (op_q == ROM_EXT && ad_q == EXT_UNLOCK) unlocked_q = 1'b1;
        if (op_q == ROM_EXT && ad_q == EXT_LOCK) unlocked_q = 1'b0;
        if (op_q == ROM_ERASE || (op_q == ROM_EXT && ad_q == EXT_CLEAR)) begin
          if (unlocked_q) begin
            for (int i = 0; i < 64; i++)
              if (op_q == ROM_EXT || i == ad_q) mem[i] = 16'hFFFF;
          end
          -> done_ev;
        end
      end
      if (n_q == 25 && (op_q == ROM_WRITE || (op_q == ROM_EXT && ad_q == EXT_FILL))) begin
        if (unlocked_q) begin
          for (int i = 0; i < 64; i++)
            if (op_q == ROM_EXT || i == ad_q) mem[i] = sh_q[15:0];
        end
        -> done_ev;
      end
    end
  end
  // Read data MSB first, shifted out after the address
  always @(negedge rom_sk) begin
    if (rom_cs && n_q >= 9 && op_q == ROM_READ) begin
      rom_do = rd_q[15];
      rd_q = {rd_q[14:0], ~rd_q[15]};
    end
  end
endmodule
`default_nettype wire

// *** serial_rom_command_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_rom_command_control_tb import srcc_pkg::*;;
  logic clk_sys, rst_n, cmd_wr, buf_wr, attached_rom_type;
  logic rom_cs, rom_sk, rom_di, rom_do;
  logic [15:0] cmd_wdata, buf_wdata, cmd_rdata, buf_rdata;
  int fail_count = 0;
  int tests_run = 0;
  srcc_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .buf_wr(buf_wr), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata),
    .attached_rom_type(attached_rom_type), .rom_cs(rom_cs), .rom_sk(rom_sk),
    .rom_di(rom_di), .rom_do(rom_do));
  srcc_rom_model ROM (.rom_cs(rom_cs), .rom_sk(rom_sk), .rom_di(rom_di), .rom_do(rom_do));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  function automatic logic [15:0] cw(logic [1:0] op, logic [1:0] sub, logic [5:0] idx,
                                     logic style);
    return {3'h0, style, 2'h0, op, sub, idx};
  endfunction
  task automatic wait_idle();
    for (int i = 0; i < 8000; i++) begin
      @(negedge clk_sys);
      if (cmd_rdata[15] === 1'b0) return;
    end
    fail_count++;
    $display("Error at %0t: busy never cleared", $time);
    tally_and_finish();
  endtask
  task automatic go(input logic [15:0] v);
    @(negedge clk_sys);
    cmd_wdata = v;
    cmd_wr = 1'b1;
    @(negedge clk_sys);
    cmd_wr = 1'b0;
    chk({15'h0, cmd_rdata[15]}, 16'h0001, "busy after command");
  endtask
  task automatic cmd(input logic [15:0] v);
    go(v);
    wait_idle();
  endtask
  task automatic buf_w(input logic [15:0] v);
    @(negedge clk_sys);
    buf_wdata = v;
    buf_wr = 1'b1;
    @(negedge clk_sys);
    buf_wr = 1'b0;
  endtask
  task automatic chk_relock();
    chk({14'h0, ROM.op_q}, {14'h0, ROM_EXT}, "last frame op");
    chk({10'h0, ROM.ad_q}, {10'h0, EXT_LOCK}, "last frame lock");
  endtask
  task automatic t_reset();
    chk(cmd_rdata, CMD_RESET, "reset value");
    @(negedge clk_sys);
    attached_rom_type = 1'b1;
    @(negedge clk_sys);
    chk(cmd_rdata, CMD_RESET | 16'h2000, "type bit");
    attached_rom_type = 1'b0;
    $display("test reset done");
  endtask
  task automatic t_store();
    buf_w(16'hA5C3);
    cmd(cw(OPC_SUB, SUB_UNLOCK, 6'h00, 1'b1));
    go(cw(OPC_STORE, 2'h0, 6'h05, 1'b1));
    buf_w(16'h1234);
    wait_idle();
    chk(ROM.mem[5], 16'hA5C3, "stored word");
    chk(buf_rdata, 16'hA5C3, "buffer write while busy");
    chk({3'h0, cmd_rdata[12:0]}, 16'h1105, "control readback");
    chk_relock();
    $display("test store done");
  endtask
  task automatic t_fetch();
    ROM.mem[9] = 16'h3C5A;
    cmd(cw(OPC_FETCH, SUB_FILL, 6'h09, 1'b1));
    chk(buf_rdata, 16'h3C5A, "fetched word");
    chk({14'h0, ROM.op_q}, {14'h0, ROM_READ}, "read frame op");
    $display("test fetch done");
  endtask
  task automatic t_style();
    buf_w(16'h0F0F);
    cmd(cw(OPC_SUB, SUB_UNLOCK, 6'h00, 1'b0));
    cmd(cw(OPC_STORE, 2'h0, 6'h02, 1'b0));
    chk(ROM.mem[6'h02 ^ SPECIAL_ADDR_XOR], 16'h0F0F, "special address");
    cmd(cw(OPC_FETCH, 2'h0, 6'h02, 1'b0));
    chk(buf_rdata, 16'h0F0F, "special fetch");
    $display("test style done");
  endtask
  task automatic t_locked();
    buf_w(16'h7777);
    cmd(cw(OPC_SUB, SUB_UNLOCK, 6'h00, 1'b1));
    cmd(cw(OPC_SUB, 2'h0, 6'h00, 1'b1));
    chk_relock();
    cmd(cw(OPC_STORE, 2'h0, 6'h05, 1'b1));
    cmd(cw(2'h3, 2'h0, 6'h05, 1'b1));
    chk(ROM.mem[5], 16'hA5C3, "locked word kept");
    $display("test locked done");
  endtask
  task automatic t_all();
    ROM.mem[4] = 16'h0000;
    cmd(cw(OPC_SUB, SUB_UNLOCK, 6'h00, 1'b1));
    cmd(cw(2'h3, 2'h0, 6'h04, 1'b1));
    chk(ROM.mem[4], 16'hFFFF, "erased word");
    chk_relock();
    buf_w(16'hBEEF);
    cmd(cw(OPC_SUB, SUB_UNLOCK, 6'h00, 1'b1));
    cmd(cw(OPC_SUB, SUB_FILL, 6'h00, 1'b1));
    chk(ROM.mem[0], 16'hBEEF, "fill first");
    chk(ROM.mem[63], 16'hBEEF, "fill last");
    chk_relock();
    cmd(cw(OPC_SUB, SUB_UNLOCK, 6'h00, 1'b1));
    cmd(cw(OPC_SUB, SUB_CLEAR, 6'h00, 1'b1));
    chk(ROM.mem[17], 16'hFFFF, "clear all");
    chk_relock();
    $display("test all done");
  endtask
  initial begin
    rst_n = 1'b0;
    cmd_wr = 1'b0;
    buf_wr = 1'b0;
    cmd_wdata = 16'h0000;
    buf_wdata = 16'h0000;
    attached_rom_type = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_store();
    t_fetch();
    t_style();
    t_locked();
    t_all();
    tally_and_finish();
  end
endmodule
`default_nettype wire
